// ---- hdl/gbvd_top.sv ----
// board glue: address decode, write-only registers, video output path and mid-line load timing
// assumes processor bus, video clock and blank inputs synchronous to ref_clk
`timescale 1ns/100ps
`default_nettype none
module gbvd_top (
	input  wire logic                ref_clk,
	input  wire logic                arst_n,
	input  wire logic [23:0]         proc_addr,
	input  wire logic [15:0]         proc_wdata,
	input  wire logic                proc_strobe,
	input  wire logic                proc_write,
	input  wire logic                host_access,
	input  wire logic                host_int_set,
	input  wire logic                host_int_clear,
	input  wire logic                secondary_processor_clock,
	input  wire logic                low_speed_video_clock,
	input  wire logic                blank_in,
	input  wire logic                hsync_in,
	input  wire logic                vsync_in,
	input  wire logic                load_req,
	input  wire logic [3:0]          serial_data,
	input  wire logic [4:0]          arb_state,
	output gbvd_pkg::gbvd_sel_t      sel_ff,
	output logic                     proc_int_n_ff,
	output logic                     host_int_ff,
	output logic [15:0]              plane_write_mask_ff,
	output logic                     led_on_ff,
	output logic                     prom_clk_en_ff,
	output logic                     gated_shift_clock_ff,
	output logic [3:0]               serial_output_enables_ff,
	output logic                     mid_line_hold_ff,
	output logic                     transfer_output_strobe_ff,
	output logic                     arb_wait_ff,
	output gbvd_pkg::gbvd_vid_t      vid_ff
);
	import gbvd_pkg::*;

	localparam logic [4:0] ST_WAIT = 5'd18;
	localparam logic [4:0] ST_PRE  = 5'd21;
	localparam logic [4:0] ST_ZERO = 5'd0;

	////////////////////////////////////////////////////////////////
	// reset release
	logic rst_a_ff;
	logic rst_n_ff;
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_a_ff <= 1'b0;
			rst_n_ff <= 1'b0;
		end else begin
			rst_a_ff <= 1'b1;
			rst_n_ff <= rst_a_ff;
		end
	end

	////////////////////////////////////////////////////////////////
	// decode
	gbvd_sel_t sel_c;
	logic      strobe_ok;
	assign strobe_ok = proc_strobe && !(host_access && proc_addr >= UART_FIRST && proc_addr <= UART_LAST);
	gbvd_decode u_dec (
		.addr   (proc_addr),
		.strobe (strobe_ok),
		.sel    (sel_c)
	);

	////////////////////////////////////////////////////////////////
	// write-only registers
	logic        wr;
	logic        nxt_proc_int_n;
	logic        nxt_host_int;
	logic [15:0] nxt_mask;
	logic        host_int_set_d_ff;
	assign wr = proc_strobe && proc_write && !host_access;
	always_comb begin
		nxt_proc_int_n = proc_int_n_ff;
		nxt_host_int = host_int_ff;
		nxt_mask = plane_write_mask_ff;
		if (host_int_set && !host_int_set_d_ff)
			nxt_proc_int_n = 1'b0;
		if (wr && proc_addr == INTCLR_ADDR)
			nxt_proc_int_n = 1'b1;
		if (wr && proc_addr == WMASK_ADDR)
			nxt_mask = proc_wdata;
		if (host_int_clear)
			nxt_host_int = 1'b0;
		if (wr && proc_addr == HINT_ADDR)
			nxt_host_int = proc_wdata[HINT_BIT];
	end
	always_ff @(posedge ref_clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			sel_ff <= '0;
			proc_int_n_ff <= 1'b1;
			host_int_ff <= 1'b0;
			plane_write_mask_ff <= WMASK_RST;
			led_on_ff <= 1'b1;
			host_int_set_d_ff <= 1'b0;
			prom_clk_en_ff <= 1'b0;
		end else begin
			sel_ff <= sel_c;
			proc_int_n_ff <= nxt_proc_int_n;
			host_int_ff <= nxt_host_int;
			plane_write_mask_ff <= nxt_mask;
			led_on_ff <= !nxt_mask[INDICATOR_FLAG_BIT];
			host_int_set_d_ff <= host_int_set;
			prom_clk_en_ff <= secondary_processor_clock && sel_c.prom;
		end
	end

	////////////////////////////////////////////////////////////////
	// video shift path
	logic        lclk_d_ff;
	logic        blank_d_ff;
	logic        lclk_rise;
	logic [15:0] shreg_ff [PLANES];
	logic [15:0] nxt_shreg [PLANES];
	logic [3:0]  word_cnt_ff;
	logic [3:0]  nxt_word_cnt;
	gbvd_vid_t   nxt_vid;
	assign lclk_rise = low_speed_video_clock && !lclk_d_ff;
	always_comb begin
		nxt_word_cnt = word_cnt_ff;
		for (int p = 0; p < PLANES; p++) begin
			nxt_shreg[p] = shreg_ff[p];
			if (lclk_rise && !blank_d_ff)
				nxt_shreg[p] = {shreg_ff[p][14:0], serial_data[p]};
		end
		if (lclk_rise && !blank_d_ff)
			nxt_word_cnt = word_cnt_ff + 4'h1;
		nxt_vid.hsync = hsync_in;
		nxt_vid.vsync = vsync_in;
		for (int p = 0; p < PLANES; p++)
			nxt_vid.pix[p] = blank_d_ff ? 1'b0 : shreg_ff[p][SHIFT_W - 1];
	end
	always_ff @(posedge ref_clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			lclk_d_ff <= 1'b0;
			blank_d_ff <= 1'b1;
			gated_shift_clock_ff <= 1'b0;
			serial_output_enables_ff <= 4'h0;
			word_cnt_ff <= 4'h0;
			vid_ff <= '0;
			for (int p = 0; p < PLANES; p++)
				shreg_ff[p] <= 16'h0000;
		end else begin
			lclk_d_ff <= low_speed_video_clock;
			blank_d_ff <= blank_in;
			gated_shift_clock_ff <= low_speed_video_clock && !blank_d_ff;
			serial_output_enables_ff <= blank_d_ff ? 4'h0 : 4'hF;
			word_cnt_ff <= nxt_word_cnt;
			vid_ff <= nxt_vid;
			for (int p = 0; p < PLANES; p++)
				shreg_ff[p] <= nxt_shreg[p];
		end
	end

	////////////////////////////////////////////////////////////////
	// mid-line reload timing
	gbvd_ld_t    ld_ff;
	gbvd_ld_t    nxt_ld;
	logic [5:0]  since_ff;
	logic [5:0]  nxt_since;
	logic        nxt_hold;
	logic        nxt_transfer_output_strobe;
	logic [4:0]  prev_state_ff;
	logic        in_window;
	assign in_window = since_ff >= 6'(LOAD_MIN_CYC) && since_ff <= 6'(LOAD_MAX_CYC);
	always_comb begin
		nxt_ld = ld_ff;
		nxt_hold = mid_line_hold_ff;
		nxt_since = lclk_rise ? 6'h00 : (since_ff == 6'h3F ? since_ff : since_ff + 6'h01);
		case (ld_ff)
			GBVD_IDLE: begin
				nxt_hold = 1'b0;
				if (load_req && !blank_d_ff) begin
					nxt_ld = GBVD_WAIT;
					nxt_hold = 1'b1;
				end
			end
			GBVD_WAIT: begin
				nxt_hold = 1'b1;
				if (blank_d_ff || in_window) begin
					nxt_ld = GBVD_LOAD;
					nxt_hold = 1'b0;
				end
			end
			GBVD_LOAD: begin
				nxt_hold = 1'b0;
				if (!load_req)
					nxt_ld = GBVD_IDLE;
			end
			default: begin
				nxt_ld = GBVD_IDLE;
				nxt_hold = 1'b0;
			end
		endcase
		nxt_transfer_output_strobe = (arb_state == ST_ZERO) && (prev_state_ff == ST_PRE);
	end
	always_ff @(posedge ref_clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			ld_ff <= GBVD_IDLE;
			since_ff <= 6'h00;
			mid_line_hold_ff <= 1'b0;
			transfer_output_strobe_ff <= 1'b0;
			arb_wait_ff <= 1'b0;
			prev_state_ff <= 5'h00;
		end else begin
			ld_ff <= nxt_ld;
			since_ff <= nxt_since;
			mid_line_hold_ff <= nxt_hold;
			transfer_output_strobe_ff <= nxt_transfer_output_strobe;
			arb_wait_ff <= (arb_state == ST_WAIT) && nxt_hold;
			prev_state_ff <= arb_state;
		end
	end
endmodule
`default_nettype wire

// ---- hdl/gbvd_pkg.sv ----
// package for the graphics board video decode block: map, register fields, video timing
// assumes a 24-bit word address from the processor and a 50 MHz board clock
//
// Notes on behaviour
// - bottom 2k words of the map select the monitor prom, 16-bit words.
// - four bit planes of 64k words at bases 0x20000 apart, plane 0 first.
// - three single addresses strobe plane-unit control, pixel latch and pixel output.
// - four one-hot addresses strobe function select for planes 0 to 3.
// - any processor write to interrupt-clear location releases the active-low processor interrupt line (drives it high).
// - plane write mask holds plane enables and flags; led lit when mask bit 4 is zero.
// - host interrupt follows written bit 0; host may also clear it.
// - video timing advances on each rising edge of the low-speed video clock.
// - each refresh transfer loads serial registers of 1024 pixels, 256 per device.
// - shift every video clock during active video, 16 pixels; clock gated by delayed blank.
// - serial outputs multiplexed by four serial output enables into four plane shifters.
// - pixels forced blank in blanking; pixels and syncs registered before output.
// - a load within blanking keeps the mid-line hold low.
// - mid-line reload only inside the safe window after a video clock rise, at any word of the line.
// - arbiter waits in state 18 until mid-line hold is low.
// - transfer happens on rising transfer strobe in state 0 after state 21.
// - monitor prom is registered, clocked by the secondary processor clock.
// - lines stored contiguously, so reloads may begin anywhere in a line.
// - mid-line refresh held until the safe window after a video clock rise; blanking load not held.
package gbvd_pkg;

	localparam int         ADDR_W       = 24;
	localparam int         DATA_W       = 16;
	localparam int         PLANES       = 4;
	localparam logic [23:0] PROM_LAST   = 24'h0007FF;
	localparam logic [23:0] PLANE_BASE  = 24'h400000;
	localparam logic [23:0] PLANE_STEP  = 24'h020000;
	localparam logic [23:0] PLANE_SIZE  = 24'h010000;
	localparam logic [23:0] CRE_ADDR    = 24'h800001;
	localparam logic [23:0] PIXEL_LATCH_STROBE_ADDR   = 24'h800002;
	localparam logic [23:0] POE_ADDR    = 24'h800004;
	localparam logic [23:0] FSE_BASE    = 24'hA00000;
	localparam logic [23:0] UART_FIRST  = 24'hC00000;
	localparam logic [23:0] UART_LAST   = 24'hC00007;
	localparam logic [23:0] INTCLR_ADDR = 24'hC00000;
	localparam logic [23:0] WMASK_ADDR  = 24'hE00007;
	localparam logic [23:0] HINT_ADDR   = 24'hF00000;
	localparam logic [15:0] WMASK_RST   = 16'h0000;
	localparam int         INDICATOR_FLAG_BIT    = 4;
	localparam int         HINT_BIT     = 0;
	localparam int         SHIFT_W      = 16;
	localparam int         LCLK_NS      = 800;
	localparam int         CLK_NS       = 20;
	localparam int         LCLK_CYC     = LCLK_NS / CLK_NS;
	localparam int         LOAD_MIN_NS  = 25;
	localparam int         LOAD_MIN_CYC = (LOAD_MIN_NS + CLK_NS) / CLK_NS;
	localparam int         LOAD_GAP_NS  = 20;
	localparam int         LOAD_MAX_CYC = (LCLK_NS - LOAD_GAP_NS) / CLK_NS;

	typedef struct packed {
		logic prom;
		logic [3:0] plane;
		logic plane_unit_ctrl_strobe;
		logic pixel_latch_strobe;
		logic pixel_output_strobe;
		logic [3:0] fse;
		logic uart;
	} gbvd_sel_t;

	typedef struct packed {
		logic hsync;
		logic vsync;
		logic [3:0] pix;
	} gbvd_vid_t;

	typedef enum logic [1:0] {
		GBVD_IDLE = 2'b00,
		GBVD_WAIT = 2'b01,
		GBVD_LOAD = 2'b10
	} gbvd_ld_t;

endpackage

// ---- hdl/gbvd_decode.sv ----
// address decoder for the processor map
// assumes address and strobe are synchronous to ref_clk
`timescale 1ns/100ps
`default_nettype none
module gbvd_decode (
	input  wire logic [23:0]       addr,
	input  wire logic              strobe,
	output gbvd_pkg::gbvd_sel_t    sel
);
	import gbvd_pkg::*;

	function automatic logic in_rng(input logic [23:0] a, input logic [23:0] lo, input logic [23:0] hi);
		in_rng = (a >= lo) && (a <= hi);
	endfunction

	always_comb begin
		sel = '0;
		if (strobe) begin
			sel.prom = in_rng(addr, 24'h000000, PROM_LAST);
			for (int p = 0; p < PLANES; p++) begin
				sel.plane[p] = in_rng(addr, PLANE_BASE + 24'(PLANE_STEP * p),
					PLANE_BASE + 24'(PLANE_STEP * p) + PLANE_SIZE - 24'h000001);
				sel.fse[p] = (addr == (FSE_BASE | (24'h000001 << p)));
			end
			sel.plane_unit_ctrl_strobe = (addr == CRE_ADDR);
			sel.pixel_latch_strobe = (addr == PIXEL_LATCH_STROBE_ADDR);
			sel.pixel_output_strobe = (addr == POE_ADDR);
			sel.uart = in_rng(addr, UART_FIRST, UART_LAST);
		end
	end
endmodule
`default_nettype wire

// ---- hdl/unused_note_guard.sv ----
`default_nettype none
`default_nettype wire

// ---- verif/gbvd_top_assertions.sv ----
// checker for gbvd_top: decode strobes, write-only registers, blanking and transfer
// assumes it is bound to gbvd_top and sees only its ports
`timescale 1ns/100ps
`default_nettype none
module gbvd_top_checker (
	input wire logic                ref_clk,
	input wire logic                arst_n,
	input wire logic [23:0]         proc_addr,
	input wire logic [15:0]         proc_wdata,
	input wire logic                proc_strobe,
	input wire logic                proc_write,
	input wire logic                host_access,
	input wire logic                blank_in,
	input wire logic [4:0]          arb_state,
	input wire gbvd_pkg::gbvd_sel_t sel_ff,
	input wire logic                proc_int_n_ff,
	input wire logic                host_int_ff,
	input wire logic [15:0]         plane_write_mask_ff,
	input wire logic                led_on_ff,
	input wire logic                gated_shift_clock_ff,
	input wire logic                mid_line_hold_ff,
	input wire logic                transfer_output_strobe_ff,
	input wire gbvd_pkg::gbvd_vid_t vid_ff
);
	import gbvd_pkg::*;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	sequence s_wr(logic [23:0] a);
		proc_strobe && proc_write && !host_access && proc_addr == a;
	endsequence
	sequence s_xfer;
		arb_state == 5'h15 ##1 arb_state == 5'h00;
	endsequence
	////////////////////////////////////////////////////////////
	AST_PROM: assert property (proc_strobe && proc_addr <= PROM_LAST |=> sel_ff.prom)
		else $error("prom select missing");
	AST_PLANE: assert property (proc_strobe && proc_addr[23:19] == 5'h08 && !proc_addr[16]
		|=> sel_ff.plane == (4'h1 << $past(proc_addr[18:17]))) else $error("plane select wrong");
	AST_BPU: assert property (proc_strobe |=> {sel_ff.plane_unit_ctrl_strobe, sel_ff.pixel_latch_strobe, sel_ff.pixel_output_strobe} ==
		{$past(proc_addr) == CRE_ADDR, $past(proc_addr) == PIXEL_LATCH_STROBE_ADDR, $past(proc_addr) == POE_ADDR})
		else $error("plane unit strobe wrong");
	AST_FSE: assert property (proc_strobe |=> sel_ff.fse == {$past(proc_addr) == 24'hA00008,
		$past(proc_addr) == 24'hA00004, $past(proc_addr) == 24'hA00002, $past(proc_addr) == 24'hA00001})
		else $error("function select strobe wrong");
	AST_UART: assert property (proc_strobe && host_access |=> !sel_ff.uart)
		else $error("serial port selected for host");
	AST_IDLE: assert property (!proc_strobe |=> sel_ff == '0)
		else $error("select without strobe");
	AST_INTCLR: assert property (s_wr(INTCLR_ADDR) |=> proc_int_n_ff)
		else $error("processor interrupt not cleared");
	AST_HINT: assert property (s_wr(HINT_ADDR) |=> host_int_ff == $past(proc_wdata[0]))
		else $error("host interrupt not following bit 0");
	AST_MASK: assert property (s_wr(WMASK_ADDR) |=> plane_write_mask_ff == $past(proc_wdata)
		&& led_on_ff == !plane_write_mask_ff[INDICATOR_FLAG_BIT]) else $error("write mask or led wrong");
	AST_HOSTWR: assert property (proc_strobe && proc_write && host_access |=> $stable(plane_write_mask_ff))
		else $error("host write changed mask");
	AST_BLANK_HOLD: assert property (blank_in |=> !mid_line_hold_ff)
		else $error("hold raised during blanking");
	AST_BLANK_PIX: assert property (blank_in [*6] |-> vid_ff.pix == 4'h0 && !gated_shift_clock_ff)
		else $error("pixels or shift clock active in blanking");
	AST_XFER: assert property (s_xfer |-> ##[0:2] transfer_output_strobe_ff)
		else $error("transfer strobe missing");
endmodule
bind gbvd_top gbvd_top_checker u_gbvd_top_checker (.*);
`default_nettype wire

// ---- verif/gbvd_vram_model.sv ----
// video dual port memory serial side: four planes of 256-bit serial registers
// assumes active-high serial output enables and a free-running video clock
`timescale 1ns/100ps
`default_nettype none
module gbvd_vram_model (
	input wire logic        ref_clk,
	input wire logic [3:0]  serial_output_enables_ff,
	input wire logic        gated_shift_clock_ff,
	input wire logic        transfer_output_strobe_ff,
	output logic            low_speed_video_clock,
	output logic [3:0]      serial_data
);
	import gbvd_pkg::*;
	int          cnt = 0;
	logic [255:0] sr [4] = '{default: '0};
	logic [3:0]  last = 4'h0;
	logic        gsc_q = 1'b0;
	logic        xfr_q = 1'b0;
	assign low_speed_video_clock = cnt < LCLK_CYC / 2;
	always @(posedge ref_clk) begin
		cnt <= (cnt == LCLK_CYC - 1) ? 0 : cnt + 1;
		gsc_q <= gated_shift_clock_ff;
		xfr_q <= transfer_output_strobe_ff;
		last <= serial_data;
		for (int i = 0; i < 4; i++) begin
			if (transfer_output_strobe_ff && !xfr_q)
				sr[i] <= {64{4'hA ^ 4'(i)}};
			else if (gated_shift_clock_ff && !gsc_q)
				sr[i] <= {sr[i][254:0], sr[i][255]};
		end
	end
	// deselected outputs show the inverse of the last value
	always_comb begin
		for (int i = 0; i < 4; i++)
			serial_data[i] = serial_output_enables_ff[i] ? sr[i][255] : ~last[i];
	end
endmodule
`default_nettype wire

// ---- verif/gbvd_top_bench.sv ----
// self-checking bench for gbvd_top against an integer model
// assumes the checker is bound and the memory model drives video clock and serial data
`timescale 1ns/100ps
`default_nettype none
module gbvd_top_bench;
	import gbvd_pkg::*;
	logic ref_clk = 1'b0, arst_n = 1'b0, proc_strobe = 1'b0, proc_write = 1'b0, host_access = 1'b0;
	logic host_int_set = 1'b0, host_int_clear = 1'b0, secondary_processor_clock = 1'b0;
	logic blank_in = 1'b1, hsync_in = 1'b0, vsync_in = 1'b0, load_req = 1'b0;
	logic [23:0] proc_addr = '0;
	logic [15:0] proc_wdata = '0;
	logic [4:0]  arb_state = '0;
	logic [3:0]  serial_data, serial_output_enables_ff;
	logic        low_speed_video_clock, proc_int_n_ff, host_int_ff, led_on_ff, prom_clk_en_ff, arb_wait_ff;
	logic        gated_shift_clock_ff, mid_line_hold_ff, transfer_output_strobe_ff;
	logic [15:0] plane_write_mask_ff;
	gbvd_sel_t   sel_ff;
	gbvd_vid_t   vid_ff;
	int          err_count = 0, check_count = 0, cyc_n = 0, m_mask = 0, m_hint = 0, m_pint = 1, n;
	logic [31:0] seed = 32'hEA52B5F6;
	logic [23:0] tab [25] = '{24'h000000, 24'h0007FF, 24'h000800, 24'h400000, 24'h40FFFF, 24'h410000,
		24'h420000, 24'h44FFFF, 24'h460000, 24'h46FFFF, 24'h480000, 24'h800001, 24'h800002, 24'h800003,
		24'h800004, 24'hA00001, 24'hA00002, 24'hA00004, 24'hA00008, 24'hA0000F, 24'hC00000, 24'hC00007,
		24'hC00008, 24'hE00007, 24'hF00000};
	gbvd_top u_gbvd_top (.*);
	gbvd_vram_model u_gbvd_vram_model (.*);
	initial forever #10 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cyc_n++;
		if (cyc_n == 5000) begin
			err_count++;
			final_report();
		end
	end
	////////////////////////////////////////////////////////////
	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tick();
		@(posedge ref_clk);
		#2;
		chk({vid_ff.hsync, vid_ff.vsync}, {hsync_in, vsync_in});
		secondary_processor_clock = ~secondary_processor_clock;
		hsync_in = seed[3];
		vsync_in = seed[9];
	endtask
	function automatic gbvd_sel_t exp_sel(input int a, input bit h);
		exp_sel = '0;
		exp_sel.prom = a <= 24'h0007FF;
		for (int p = 0; p < 4; p++) begin
			exp_sel.plane[p] = a >= 24'h400000 + p * 24'h020000 && a < 24'h410000 + p * 24'h020000;
			exp_sel.fse[p] = a == 24'hA00000 + (1 << p);
		end
		exp_sel.plane_unit_ctrl_strobe = a == 24'h800001;
		exp_sel.pixel_latch_strobe = a == 24'h800002;
		exp_sel.pixel_output_strobe = a == 24'h800004;
		exp_sel.uart = !h && a >= 24'hC00000 && a <= 24'hC00007;
	endfunction
	task automatic regs();
		chk({proc_int_n_ff, host_int_ff, led_on_ff, plane_write_mask_ff}, {m_pint[0], m_hint[0], !m_mask[4], m_mask[15:0]});
	endtask
	task automatic acc(input logic [23:0] a, input logic [15:0] d, input logic w, input logic h);
		proc_addr = a;
		proc_wdata = d;
		proc_write = w;
		host_access = h;
		proc_strobe = 1'b1;
		tick();
		if (w && !h && a == INTCLR_ADDR)
			m_pint = 1;
		if (w && !h && a == WMASK_ADDR)
			m_mask = d;
		if (w && !h && a == HINT_ADDR)
			m_hint = d[0];
		chk(sel_ff, exp_sel(a, h));
		chk(prom_clk_en_ff, !secondary_processor_clock && a <= 24'h0007FF);
		regs();
	endtask
	task automatic idle(input int k);
		proc_strobe = 1'b0;
		repeat (k) tick();
	endtask
	task automatic rnd();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
	endtask
	////////////////////////////////////////////////////////////
	initial begin
		repeat (12) @(posedge ref_clk);
		#2 arst_n = 1'b1;
		idle(3);
		regs();
		foreach (tab[i]) begin
			acc(tab[i], 16'h0000, 1'b0, 1'b0);
			acc(tab[i], 16'h0000, 1'b0, 1'b1);
		end
		repeat (40) begin
			rnd();
			acc(seed[23:0], seed[31:16], 1'b1, seed[5]);
		end
		for (int i = 0; i < 4; i++) begin
			rnd();
			acc(WMASK_ADDR, {seed[15:5], i[0], seed[3:0]}, 1'b1, i[1]);
		end
		acc(HINT_ADDR, 16'h0001, 1'b1, 1'b0);
		acc(HINT_ADDR, 16'hFFFE, 1'b1, 1'b0);
		host_int_clear = 1'b1;
		acc(HINT_ADDR, 16'h0001, 1'b1, 1'b0);
		idle(1);
		host_int_clear = 1'b0;
		m_hint = 0;
		host_int_set = 1'b1;
		idle(3);
		m_pint = 0;
		regs();
		host_int_set = 1'b0;
		acc(INTCLR_ADDR, seed[15:0], 1'b1, 1'b0);
		host_int_set = 1'b1;
		acc(INTCLR_ADDR, 16'h0000, 1'b1, 1'b0);
		idle(3);
		regs();
		load_req = 1'b1;
		idle(10);
		chk({vid_ff.pix, gated_shift_clock_ff, mid_line_hold_ff}, 6'h00);
		arb_state = 5'h12;
		blank_in = 1'b0;
		n = 0;
		repeat (100) begin
			tick();
			n += arb_wait_ff;
		end
		chk(n > 0, 1);
		chk(serial_output_enables_ff, 4'hF);
		arb_state = 5'h12;
		idle(4);
		arb_state = 5'h15;
		idle(1);
		arb_state = 5'h00;
		n = 0;
		repeat (3) begin
			tick();
			n += transfer_output_strobe_ff;
		end
		chk(n, 1);
		final_report();
	end
endmodule
`default_nettype wire
